// *** psq_defs.svh ***
`ifndef PSQ_DEFS_SVH
`define PSQ_DEFS_SVH

// ----------------------------------------------------------------
// counter geometry
// ----------------------------------------------------------------
`define PSQ_PC_W 14
`define PSQ_OFS_W 7
`define PSQ_PAGE_W 7
`define PSQ_OFS_LAST 7'h7f
`define PSQ_ROM_W 10
`define PSQ_TBL_W 8
`define PSQ_SP_RESET 3'h7
`define PSQ_PAGE_ONE 7'h01
`define PSQ_PAGE_TWO 7'h02
`define PSQ_TBL_PAGE_W 6

// ----------------------------------------------------------------
// register file offsets (byte addresses)
// ----------------------------------------------------------------
`define PSQ_REG_CTRL 8'h00
`define PSQ_REG_PC 8'h04
`define PSQ_REG_SP 8'h08
`define PSQ_REG_DP 8'h0c
`define PSQ_REG_CTX 8'h10
`define PSQ_REG_FLAGS 8'h14
`define PSQ_REG_TBL 8'h18
`define PSQ_CTRL_RUN_BIT 0
`define PSQ_CTRL_BACKUP_BIT 1

`endif

// *** psq_pkg.sv ***
`default_nettype none
`include "psq_defs.svh"

package psq_pkg;

    // instruction classes presented by the decoder
    typedef enum logic [3:0] {
        PSQ_OP_NONE,
        PSQ_OP_SEQ,
        PSQ_OP_BRANCH,
        PSQ_OP_CALL,
        PSQ_OP_CALL_PAGE2,
        PSQ_OP_RET,
        PSQ_OP_RETI,
        PSQ_OP_TABLE,
        PSQ_OP_BANK_HI,
        PSQ_OP_BANK_LO,
        PSQ_OP_INTR
    } psq_op_t;

    // ram pointer: group, file, digit
    typedef struct packed {
        logic grp;
        logic [3:0] file;
        logic [3:0] digit;
    } psq_dp_t;

    // interrupt context store contents
    typedef struct packed {
        psq_dp_t dp;
        logic carry;
        logic skip;
        logic [3:0] acc;
        logic [3:0] breg;
    } psq_ctx_t;

    // one instruction step from the decoder
    typedef struct packed {
        psq_op_t op;
        logic [1:0] len;
        logic [13:0] target;
        logic [6:0] tbl_ofs;
    } psq_step_t;

endpackage : psq_pkg

`default_nettype wire

// *** psq_sequencer.sv ***
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "psq_defs.svh"

module psq_sequencer
    import psq_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    // instruction stream
    input wire psq_step_t STEP,
    input wire logic STEP_VALID,
    input wire logic [6:0] INT_VECTOR,
    input wire psq_ctx_t CUR_CTX,
    input wire psq_dp_t DP_LOAD,
    input wire logic DP_LOAD_EN,
    input wire logic [`PSQ_ROM_W-1:0] ROM_DATA,
    output logic [`PSQ_PC_W-1:0] ROM_ADDR,
    output logic [`PSQ_PC_W-1:0] PC_OUT,
    output logic [2:0] SP_OUT,
    output psq_dp_t DP_OUT,
    output logic [3:0] PORT_BIT_POS,
    output psq_ctx_t CTX_OUT,
    output logic CTX_RESTORE,
    output logic [`PSQ_TBL_W-1:0] TBL_DATA,
    output logic TBL_VALID,
    // axi4-lite slave
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [`PSQ_PC_W-1:0] instruction_counter_ff;
    logic [`PSQ_PC_W-1:0] call_stack_slot_ff [8];
    logic [2:0] stack_level_pointer_ff;
    psq_dp_t ram_pointer_ff;
    psq_ctx_t interrupt_context_store_ff;
    logic upper_bank_select_ff;
    logic tbl_pending_ff;
    logic [`PSQ_PC_W-1:0] tbl_return_ff;
    logic run_ff;
    logic backup_ff;
    logic backup_prev_ff;
    logic [`PSQ_TBL_W-1:0] tbl_data_ff;
    logic tbl_valid_ff;
    logic ctx_restore_ff;

    logic [`PSQ_PC_W-1:0] nxt_pc;
    logic [2:0] nxt_sp;
    logic push;
    logic pop;
    logic go;
    logic backup_exit;

    // wrapping pointer arithmetic, used by push and pop
    function automatic logic [2:0] sp_step(input logic [2:0] sp, input logic up);
        sp_step = up ? 3'(sp + 3'h1) : 3'(sp - 3'h1);
    endfunction

    // sequential advance: offset rollover carries into page
    function automatic logic [`PSQ_PC_W-1:0] pc_advance(input logic [`PSQ_PC_W-1:0] pc,
                                                        input logic [1:0] len);
        pc_advance = `PSQ_PC_W'(pc + `PSQ_PC_W'(len));
    endfunction

    assign go = CE && run_ff && STEP_VALID;
    assign backup_exit = backup_prev_ff && !backup_ff;

    // ----------------------------------------------------------------
    // next counter and pointer
    // ----------------------------------------------------------------
    // table fetch: ride one cycle on the fetched address, then come back
    always_comb begin
        nxt_pc = instruction_counter_ff;
        nxt_sp = stack_level_pointer_ff;
        push = 1'b0;
        pop = 1'b0;
        if (tbl_pending_ff) begin
            nxt_pc = tbl_return_ff;
            nxt_sp = sp_step(stack_level_pointer_ff, 1'b0);
        end else begin
            case (STEP.op)
                PSQ_OP_SEQ, PSQ_OP_BANK_HI, PSQ_OP_BANK_LO: begin
                    nxt_pc = pc_advance(instruction_counter_ff, STEP.len);
                end
                PSQ_OP_BRANCH: begin
                    nxt_pc = STEP.target;
                end
                PSQ_OP_CALL: begin
                    nxt_pc = STEP.target;
                    push = 1'b1;
                end
                PSQ_OP_CALL_PAGE2: begin
                    nxt_pc = {`PSQ_PAGE_TWO, STEP.target[`PSQ_OFS_W-1:0]};
                    push = 1'b1;
                end
                PSQ_OP_INTR: begin
                    nxt_pc = {`PSQ_PAGE_ONE, INT_VECTOR};
                    push = 1'b1;
                end
                PSQ_OP_TABLE: begin
                    // page from low bank bits plus select, offset from decoder
                    nxt_pc = {upper_bank_select_ff, STEP.target[`PSQ_PC_W-2:`PSQ_OFS_W],
                              STEP.tbl_ofs};
                    push = 1'b1;
                end
                PSQ_OP_RET, PSQ_OP_RETI: begin
                    // the popped slot keeps its value until a later push
                    nxt_pc = call_stack_slot_ff[stack_level_pointer_ff];
                    pop = 1'b1;
                end
                default: begin
                    nxt_pc = instruction_counter_ff;
                end
            endcase
            if (push) begin
                nxt_sp = sp_step(stack_level_pointer_ff, 1'b1);
            end else if (pop) begin
                nxt_sp = sp_step(stack_level_pointer_ff, 1'b0);
            end
        end
    end

    // program counter
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            instruction_counter_ff <= '0;
        end else if (go || (CE && tbl_pending_ff)) begin
            instruction_counter_ff <= nxt_pc;
        end
    end

    // level pointer; backup release forces 7 like reset
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            stack_level_pointer_ff <= `PSQ_SP_RESET;
        end else if (CE && backup_exit) begin
            stack_level_pointer_ff <= `PSQ_SP_RESET;
        end else if (go || (CE && tbl_pending_ff)) begin
            stack_level_pointer_ff <= nxt_sp;
        end
    end

    // return slots: write at the freshly advanced level
    // no reset: a slot is undefined until a push fills it
    always_ff @(posedge CLK) begin
        if (go && !tbl_pending_ff && push) begin
            if (STEP.op == PSQ_OP_INTR) begin
                call_stack_slot_ff[nxt_sp] <= instruction_counter_ff;
            end else begin
                // return address is the instruction after the call
                call_stack_slot_ff[nxt_sp] <= pc_advance(instruction_counter_ff,
                                                         STEP.len);
            end
        end
    end

    // table fetch bookkeeping and returned byte
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            tbl_pending_ff <= 1'b0;
            tbl_return_ff <= '0;
            tbl_data_ff <= '0;
            tbl_valid_ff <= 1'b0;
        end else if (CE) begin
            tbl_valid_ff <= 1'b0;
            if (tbl_pending_ff) begin
                tbl_pending_ff <= 1'b0;
                tbl_data_ff <= ROM_DATA[`PSQ_TBL_W-1:0];
                tbl_valid_ff <= 1'b1;
            end else if (go && STEP.op == PSQ_OP_TABLE) begin
                tbl_pending_ff <= 1'b1;
                tbl_return_ff <= pc_advance(instruction_counter_ff, STEP.len);
            end
        end
    end

    // bank select, lower bank after reset
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            upper_bank_select_ff <= 1'b0;
        end else if (go && !tbl_pending_ff) begin
            if (STEP.op == PSQ_OP_BANK_HI) begin
                upper_bank_select_ff <= 1'b1;
            end else if (STEP.op == PSQ_OP_BANK_LO) begin
                upper_bank_select_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // ram pointer and interrupt context
    // ----------------------------------------------------------------
    // the whole ram pointer is left unreset on purpose: software must load it
    always_ff @(posedge CLK) begin
        if (CE && DP_LOAD_EN) begin
            ram_pointer_ff <= DP_LOAD;
        end
    end

    // only interrupt entry writes it; calls and table fetches pass by
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            interrupt_context_store_ff <= '0;
            ctx_restore_ff <= 1'b0;
        end else if (CE) begin
            ctx_restore_ff <= 1'b0;
            if (go && !tbl_pending_ff && STEP.op == PSQ_OP_INTR) begin
                interrupt_context_store_ff <= CUR_CTX;
            end else if (go && !tbl_pending_ff && STEP.op == PSQ_OP_RETI) begin
                ctx_restore_ff <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // all straight from flops, so the decoder sees no comb loop
    assign ROM_ADDR = instruction_counter_ff;
    assign PC_OUT = instruction_counter_ff;
    assign SP_OUT = stack_level_pointer_ff;
    assign DP_OUT = ram_pointer_ff;
    assign PORT_BIT_POS = ram_pointer_ff.digit;
    assign CTX_OUT = interrupt_context_store_ff;
    assign CTX_RESTORE = ctx_restore_ff;
    assign TBL_DATA = tbl_data_ff;
    assign TBL_VALID = tbl_valid_ff;

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    logic aw_got_ff;
    logic w_got_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    assign AWREADY = !aw_got_ff && !bvalid_ff;
    assign WREADY = !w_got_ff && !bvalid_ff;
    assign ARREADY = !rvalid_ff;
    assign BVALID = bvalid_ff;
    assign BRESP = bresp_ff;
    assign RVALID = rvalid_ff;
    assign RDATA = rdata_ff;
    assign RRESP = rresp_ff;

    // capture address and data in either order, answer when both held
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
        end else if (CE) begin
            if (AWVALID && AWREADY) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_got_ff <= 1'b1;
                wdata_ff <= WDATA;
                wstrb_ff <= WSTRB;
            end
            if (aw_got_ff && w_got_ff) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= (awaddr_ff == `PSQ_REG_CTRL) ? 2'h0 : 2'h2;
            end else if (bvalid_ff && BREADY) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // control register: run gate and backup mode
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            run_ff <= 1'b1;
            backup_ff <= 1'b0;
            backup_prev_ff <= 1'b0;
        end else if (CE) begin
            backup_prev_ff <= backup_ff;
            if (aw_got_ff && w_got_ff && awaddr_ff == `PSQ_REG_CTRL && wstrb_ff[0]) begin
                run_ff <= wdata_ff[`PSQ_CTRL_RUN_BIT];
                backup_ff <= wdata_ff[`PSQ_CTRL_BACKUP_BIT];
            end
        end
    end

    // read mux; unmapped offsets answer slverr with zero data
    // trade-off: state is captured at the address edge, not when rready rises
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= 2'h0;
        end else if (CE) begin
            if (ARVALID && ARREADY) begin
                rvalid_ff <= 1'b1;
                rresp_ff <= 2'h0;
                case (ARADDR)
                    `PSQ_REG_CTRL: rdata_ff <= {30'h0, backup_ff, run_ff};
                    `PSQ_REG_PC: rdata_ff <= {18'h0, instruction_counter_ff};
                    `PSQ_REG_SP: rdata_ff <= {29'h0, stack_level_pointer_ff};
                    `PSQ_REG_DP: rdata_ff <= {23'h0, ram_pointer_ff};
                    `PSQ_REG_CTX: rdata_ff <= {13'h0, interrupt_context_store_ff};
                    `PSQ_REG_FLAGS: rdata_ff <= {30'h0, tbl_pending_ff, upper_bank_select_ff};
                    `PSQ_REG_TBL: rdata_ff <= {24'h0, tbl_data_ff};
                    default: begin
                        rdata_ff <= '0;
                        rresp_ff <= 2'h2;
                    end
                endcase
            end else if (rvalid_ff && RREADY) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

endmodule // psq_sequencer

`default_nettype wire

// *** psq_sequencer_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none

module psq_sequencer_asserts
    import psq_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire psq_step_t STEP,
    input wire logic STEP_VALID,
    input wire logic [6:0] INT_VECTOR,
    input wire logic [9:0] ROM_DATA,
    input wire psq_dp_t DP_LOAD,
    input wire psq_ctx_t CUR_CTX,
    input wire logic DP_LOAD_EN,
    input wire logic [13:0] PC_OUT,
    input wire logic [2:0] SP_OUT,
    input wire psq_dp_t DP_OUT,
    input wire logic [3:0] PORT_BIT_POS,
    input wire logic CTX_RESTORE,
    input wire psq_ctx_t CTX_OUT,
    input wire logic [7:0] TBL_DATA,
    input wire logic TBL_VALID
);
    // ------------------------------------------------------------
    // step acceptance
    // ------------------------------------------------------------
    logic tbl_pend_ff;
    logic take;

    // limitation: assumes the run bit stays set, it is not visible here
    assign take = CE && STEP_VALID && !tbl_pend_ff;

    // the slot after a table fetch refuses any step
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            tbl_pend_ff <= 1'b0;
        end else if (CE) begin
            tbl_pend_ff <= take && STEP.op == PSQ_OP_TABLE;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    sequence s_take(psq_op_t o);
        take && STEP.op == o;
    endsequence

    AST_RST_SP: assert property ($rose(RST_B) |-> SP_OUT == 3'h7)
        else $error("stack level wrong after reset");
    AST_CALL: assert property (s_take(PSQ_OP_CALL) |=>
        SP_OUT == $past(SP_OUT) + 3'h1 && PC_OUT == $past(STEP.target))
        else $error("call did not push or jump");
    AST_SEQ: assert property (s_take(PSQ_OP_SEQ) |=>
        PC_OUT == $past(PC_OUT) + 14'($past(STEP.len)))
        else $error("sequential step wrong");
    AST_INTR: assert property (s_take(PSQ_OP_INTR) |=>
        PC_OUT == {7'h01, $past(INT_VECTOR)} && SP_OUT == $past(SP_OUT) + 3'h1)
        else $error("interrupt vector wrong");
    AST_PAGE2: assert property (s_take(PSQ_OP_CALL_PAGE2) |=>
        PC_OUT[13:7] == 7'h02 && PC_OUT[6:0] == $past(STEP.target[6:0]))
        else $error("page two call target wrong");
    AST_RET: assert property (s_take(PSQ_OP_RET) |=> SP_OUT == $past(SP_OUT) - 3'h1)
        else $error("return did not pop");
    AST_RETI: assert property (s_take(PSQ_OP_RETI) |=> CTX_RESTORE ##1 !CTX_RESTORE)
        else $error("restore pulse wrong");
    AST_TBL: assert property (s_take(PSQ_OP_TABLE) |-> ##2
        TBL_VALID && TBL_DATA == $past(ROM_DATA[7:0]) && SP_OUT == $past(SP_OUT, 2))
        else $error("table fetch data wrong");
    AST_DP: assert property (CE && DP_LOAD_EN |=> DP_OUT == $past(DP_LOAD))
        else $error("ram pointer not loaded");
    AST_PORT: assert property (CE && DP_LOAD_EN |=> PORT_BIT_POS == $past(DP_LOAD.digit))
        else $error("port bit position differs from loaded digit");
    AST_CTX_SAVE: assert property (s_take(PSQ_OP_INTR) |=> CTX_OUT == $past(CUR_CTX))
        else $error("interrupt context not saved");
    AST_CTX_HOLD: assert property (take && STEP.op inside {PSQ_OP_CALL, PSQ_OP_TABLE} |=>
        $stable(CTX_OUT))
        else $error("context store touched by call or table fetch");

endmodule // psq_sequencer_asserts

bind psq_sequencer psq_sequencer_asserts i_psq_sequencer_asserts (
    .CLK(CLK), .RST_B(RST_B), .CE(CE), .STEP(STEP), .STEP_VALID(STEP_VALID),
    .INT_VECTOR(INT_VECTOR), .ROM_DATA(ROM_DATA), .DP_LOAD(DP_LOAD),
    .DP_LOAD_EN(DP_LOAD_EN), .PC_OUT(PC_OUT), .SP_OUT(SP_OUT), .DP_OUT(DP_OUT),
    .CUR_CTX(CUR_CTX), .CTX_OUT(CTX_OUT),
    .PORT_BIT_POS(PORT_BIT_POS), .CTX_RESTORE(CTX_RESTORE), .TBL_DATA(TBL_DATA),
    .TBL_VALID(TBL_VALID)
);

`default_nettype wire

// *** psq_sequencer_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module psq_sequencer_tb_top
    import psq_pkg::*;
;
    logic clk, rst_b, ce, step_valid, dp_load_en, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, ctx_restore, tbl_valid;
    logic [1:0] bresp, rresp;
    logic [3:0] wstrb, port_bit_pos;
    logic [6:0] int_vector;
    logic [7:0] awaddr, araddr, tbl_data;
    logic [2:0] sp_out;
    logic [9:0] rom_data;
    logic [13:0] rom_addr, pc_out;
    logic [31:0] wdata, rdata, rd;
    psq_step_t step;
    psq_ctx_t cur_ctx, ctx_out, saved;
    psq_dp_t dp_load, dp_out;
    int bad_count = 0;
    int samples_checked = 0;
    int pc, sp, bank, stk[8];
    psq_op_t ops[8] = '{PSQ_OP_SEQ, PSQ_OP_BRANCH, PSQ_OP_CALL, PSQ_OP_CALL_PAGE2,
        PSQ_OP_RET, PSQ_OP_TABLE, PSQ_OP_BANK_HI, PSQ_OP_BANK_LO};

    // ------------------------------------------------------------
    // clock, rom and design
    // ------------------------------------------------------------
    initial clk = 1'b0;
    always #5 clk = ~clk;
    // rom pattern scrambled so the low byte differs from the address
    assign rom_data = rom_addr[9:0] ^ 10'h2b6;

    psq_sequencer i_psq_sequencer (
        .CLK(clk), .RST_B(rst_b), .CE(ce), .STEP(step), .STEP_VALID(step_valid),
        .INT_VECTOR(int_vector), .CUR_CTX(cur_ctx), .DP_LOAD(dp_load),
        .DP_LOAD_EN(dp_load_en), .ROM_DATA(rom_data), .ROM_ADDR(rom_addr), .PC_OUT(pc_out),
        .SP_OUT(sp_out), .DP_OUT(dp_out), .PORT_BIT_POS(port_bit_pos), .CTX_OUT(ctx_out),
        .CTX_RESTORE(ctx_restore), .TBL_DATA(tbl_data), .TBL_VALID(tbl_valid),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
        .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
        .RVALID(rvalid), .RREADY(rready)
    );

    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk_val(logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        bready <= 1'b0;
        chk_val(bvalid, 1);
        chk_val(bresp, er);
    endtask

    task automatic rd_reg(logic [7:0] a, logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        rready <= 1'b0;
        rd = rdata;
        chk_val(rvalid, 1);
        chk_val(rresp, er);
    endtask

    // one instruction through design and reference model
    task automatic run(psq_op_t op, logic [1:0] len, logic [13:0] tgt);
        int tpc;
        @(posedge clk);
        step <= '{op, len, tgt, tgt[6:0]};
        step_valid <= 1'b1;
        @(posedge clk);
        step_valid <= op == PSQ_OP_TABLE;
        tpc = pc + len;
        case (op)
            PSQ_OP_BRANCH: tpc = tgt;
            PSQ_OP_CALL, PSQ_OP_CALL_PAGE2, PSQ_OP_INTR, PSQ_OP_TABLE: begin
                sp = (sp + 1) % 8;
                stk[sp] = (op == PSQ_OP_INTR) ? pc : tpc;
                if (op == PSQ_OP_INTR) saved = cur_ctx;
                tpc = op == PSQ_OP_CALL ? tgt : op == PSQ_OP_CALL_PAGE2 ? 256 + tgt[6:0] :
                    op == PSQ_OP_INTR ? 128 + int_vector : bank * 8192 + tgt[12:0];
            end
            PSQ_OP_RET, PSQ_OP_RETI: begin
                tpc = stk[sp];
                sp = (sp + 7) % 8;
            end
            PSQ_OP_BANK_HI, PSQ_OP_BANK_LO: bank = op == PSQ_OP_BANK_HI;
            default: ;
        endcase
        #1;
        chk_val(pc_out, tpc % 16384);
        chk_val(rom_addr, tpc % 16384);
        chk_val(sp_out, sp);
        if (op == PSQ_OP_RETI) begin
            chk_val(ctx_restore, 1);
            chk_val(ctx_out, saved);
        end
        if (op == PSQ_OP_TABLE) begin
            @(posedge clk);
            step_valid <= 1'b0;
            sp = (sp + 7) % 8;
            #1;
            chk_val(tbl_valid, 1);
            chk_val(tbl_data, (tpc ^ 'h2b6) & 'hff);
            tpc = pc + len;
            chk_val(pc_out, tpc % 16384);
            chk_val(sp_out, sp);
        end
        pc = tpc % 16384;
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {rst_b, step_valid, dp_load_en, awvalid, wvalid, bready, arvalid, rready} = '0;
        {step, int_vector, cur_ctx, dp_load, awaddr, wdata, araddr} = '0;
        ce = 1'b1;
        wstrb = 4'hf;
        pc = 0;
        sp = 7;
        rd = $urandom(32'hc002);
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk_val(sp_out, 7);
        chk_val(pc_out, 0);
        wr(8'h00, 32'h1, 2'b00);
        wr(8'h04, 32'h5, 2'b10);
        rd_reg(8'h20, 2'b10);
        chk_val(rd, 0);
        run(PSQ_OP_BANK_LO, 2'd1, 14'h0);
        run(PSQ_OP_BRANCH, 2'd1, 14'h2fe);
        run(PSQ_OP_SEQ, 2'd2, 14'h0);
        run(PSQ_OP_TABLE, 2'd1, 14'h3abc);
        run(PSQ_OP_BANK_HI, 2'd1, 14'h0);
        run(PSQ_OP_TABLE, 2'd2, 14'h0123);
        for (int i = 0; i < 9; i++) run(PSQ_OP_CALL, 2'($urandom_range(1, 3)), 14'($urandom));
        rd_reg(8'h08, 2'b00);
        chk_val(rd, sp);
        for (int i = 0; i < 9; i++) run(PSQ_OP_RET, 2'd1, 14'h0);
        run(PSQ_OP_CALL_PAGE2, 2'd1, 14'h3f7e);
        run(PSQ_OP_SEQ, 2'd3, 14'h0);
        run(PSQ_OP_RET, 2'd1, 14'h0);
        @(posedge clk);
        dp_load <= 9'($urandom);
        dp_load_en <= 1'b1;
        @(posedge clk);
        dp_load_en <= 1'b0;
        #1;
        chk_val(dp_out, dp_load);
        chk_val(port_bit_pos, dp_load.digit);
        // frozen clock enable: a held branch must not be taken
        @(posedge clk);
        ce <= 1'b0;
        step <= '{PSQ_OP_BRANCH, 2'd1, 14'h1234, 7'h34};
        step_valid <= 1'b1;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        step_valid <= 1'b0;
        #1;
        chk_val(pc_out, pc);
        chk_val(sp_out, sp);
        cur_ctx <= 19'($urandom);
        int_vector <= 7'($urandom);
        run(PSQ_OP_INTR, 2'd2, 14'h0);
        cur_ctx <= ~cur_ctx;
        run(PSQ_OP_CALL, 2'd1, 14'($urandom));
        run(PSQ_OP_TABLE, 2'd1, 14'($urandom));
        run(PSQ_OP_RET, 2'd1, 14'h0);
        run(PSQ_OP_RETI, 2'd1, 14'h0);
        for (int i = 0; i < 40; i++) run(ops[$urandom % 8], 2'($urandom_range(1, 3)), 14'($urandom));
        wr(8'h00, 32'h3, 2'b00);
        wr(8'h00, 32'h1, 2'b00);
        #1;
        chk_val(sp_out, 7);
        conclude();
    end

    // a hang is counted as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        conclude();
    end

endmodule // psq_sequencer_tb_top

`default_nettype wire
